//--- hdl/dsr_pkg.sv
// Constants and types shared by the dual serial register decoder.
package dsr_pkg;
	// Widths and counts.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 4;
	localparam int unsigned NUM_CH = 2;
	localparam int unsigned NUM_SHARED = 10;
	localparam int unsigned NUM_DMA = 4;
	// Regions, selected by the address bits above the 256-byte window.
	localparam logic [3:0] RGN_PREF = 4'h0;
	localparam logic [3:0] RGN_LEGACY = 4'h1;
	localparam logic [3:0] RGN_DMA_BASE = 4'h2;
	// Per-channel offsets, index 0 is channel A and index 1 is channel B.
	localparam logic [1:0][7:0] OFF_PREF_CMD = {8'h00, 8'h20};
	localparam logic [1:0][7:0] OFF_PREF_DATA = {8'h10, 8'h30};
	localparam logic [1:0][7:0] OFF_PREF_EXT = {8'h40, 8'h50};
	localparam logic [1:0][7:0] OFF_LEG_CMD = {8'h00, 8'h02};
	localparam logic [1:0][7:0] OFF_LEG_DATA = {8'h04, 8'h06};
	localparam logic [1:0][7:0] OFF_LEG_EXT = {8'h08, 8'h0A};
	// Shared slots: recovery, start A, start B, detect, timer, match 1-3, match detect, mask.
	localparam logic [9:0][7:0] OFF_SHARED = {8'hE0, 8'hD0, 8'hC0, 8'hB0, 8'hA0,
		8'h90, 8'h80, 8'h70, 8'h70, 8'h60};
	// Offsets inside each descriptor DMA region.
	localparam logic [7:0] DMA_OFF_CTRL = 8'h00;
	localparam logic [7:0] DMA_OFF_COUNT = 8'h10;
	localparam logic [7:0] DMA_OFF_LEVEL = 8'h20;
	localparam int unsigned DMA_CTRL_EN_BIT = 0;
	// Indirect register pointers behind each command register.
	localparam logic [1:0] IND_CTRL = 2'h0;
	localparam logic [1:0] IND_MODE = 2'h1;
	localparam logic [1:0] IND_STATUS = 2'h2;
	localparam int unsigned MODE_CLK_EXT_BIT = 0;
	// Status bit positions.
	localparam int unsigned ST_RX_AVAIL = 0;
	localparam int unsigned ST_TX_ROOM = 1;
	localparam int unsigned ST_EXT_CLK = 2;
	localparam int unsigned ST_TX_EMPTY = 3;
	// Reset value of every storage byte.
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic {
		PH_INDEX = 1'b0,
		PH_VALUE = 1'b1
	} dsr_phase_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} dsr_bus_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] mode;
		logic [DATA_W-1:0] ext;
	} dsr_chan_cfg_t;
endpackage

//--- hdl/dsr_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module dsr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Filling side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Fill level.
	output logic [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] cnt;
	} dsr_fifo_state_t;

	dsr_fifo_state_t st_q;
	dsr_fifo_state_t st_d;
	logic push;
	logic pop;

	assign in_ready_o = (st_q.cnt != CW'(DEPTH));
	assign out_valid_o = (st_q.cnt != '0);
	assign out_data_o = st_q.mem[st_q.rptr];
	assign level_o = st_q.cnt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wptr] = in_data_i;
			st_d.wptr = PW'(st_q.wptr + 1'b1);
		end
		if (pop) begin
			st_d.rptr = PW'(st_q.rptr + 1'b1);
		end
		if (push && !pop) begin
			st_d.cnt = CW'(st_q.cnt + 1'b1);
		end else if (pop && !push) begin
			st_d.cnt = CW'(st_q.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule // dsr_fifo
`default_nettype wire

//--- hdl/dsr_decoder.sv
// Register decoder and data path of the dual serial channel controller.
`timescale 1ns/100ps
`default_nettype none
module dsr_decoder (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port.
	input wire dsr_pkg::dsr_bus_req_t bus_req_i,
	output logic [7:0] reg_rdata_o,
	// Serial engine transmit streams.
	output logic [1:0] ser_tx_valid_o,
	input wire logic [1:0] ser_tx_ready_i,
	output logic [1:0][7:0] ser_tx_data_o,
	// Serial engine receive streams.
	input wire logic [1:0] ser_rx_valid_i,
	output logic [1:0] ser_rx_ready_o,
	input wire logic [1:0][7:0] ser_rx_data_i,
	// Descriptor DMA transmit streams.
	input wire logic [1:0] dma_tx_valid_i,
	output logic [1:0] dma_tx_ready_o,
	input wire logic [1:0][7:0] dma_tx_data_i,
	// Descriptor DMA receive streams.
	output logic [1:0] dma_rx_valid_o,
	input wire logic [1:0] dma_rx_ready_i,
	output logic [1:0][7:0] dma_rx_data_o,
	// Serial clock source.
	input wire logic [1:0] external_serial_clock_pin_i,
	output logic [1:0] clk_src_ext_o,
	// Configuration towards the serial engine and the net assist logic.
	output dsr_pkg::dsr_chan_cfg_t [1:0] chan_cfg_o,
	output logic [9:0][7:0] shared_regs_o
);
	localparam int unsigned LW = $clog2(dsr_pkg::FIFO_DEPTH + 1);

	typedef struct packed {
		dsr_pkg::dsr_phase_t [1:0] phase;
		logic [1:0][1:0] ptr;
		dsr_pkg::dsr_chan_cfg_t [1:0] cfg;
		logic [9:0][7:0] shared;
		logic [3:0] dma_en;
		logic [3:0][7:0] dma_cnt;
		logic [1:0][2:0] sync;
		logic [1:0] ext_lvl;
		logic [7:0] rdata;
	} dsr_state_t;

	dsr_state_t st_q;
	dsr_state_t st_d;

	// Decode results.
	logic [3:0] region;
	logic [7:0] off;
	logic in_window;
	logic [1:0] hit_cmd;
	logic [1:0] hit_data;
	logic [1:0] hit_ext;
	logic [9:0] hit_sh;
	logic [3:0] hit_dctl;
	logic [3:0] hit_dcnt;
	logic [3:0] hit_dlvl;
	logic [1:0] wr_data;
	logic [1:0] rd_data;
	logic [1:0][7:0] status;

	// FIFO signals; index 2*ch is transmit, 2*ch+1 is receive.
	logic [3:0] fin_valid;
	logic [3:0] fin_ready;
	logic [3:0][7:0] fin_data;
	logic [3:0] fout_valid;
	logic [3:0] fout_ready;
	logic [3:0][7:0] fout_data;
	logic [3:0][LW-1:0] flevel;
	logic [3:0] dma_xfer;

	// Address decode.
	always_comb begin
		region = bus_req_i.addr[11:8];
		off = bus_req_i.addr[7:0];
		in_window = (region == dsr_pkg::RGN_PREF) || (region == dsr_pkg::RGN_LEGACY);
		for (int ch = 0; ch < 2; ch++) begin
			if (region == dsr_pkg::RGN_PREF) begin
				hit_cmd[ch] = (off == dsr_pkg::OFF_PREF_CMD[ch]);
				hit_data[ch] = (off == dsr_pkg::OFF_PREF_DATA[ch]);
				hit_ext[ch] = (off == dsr_pkg::OFF_PREF_EXT[ch]);
			end else if (region == dsr_pkg::RGN_LEGACY) begin
				hit_cmd[ch] = (off == dsr_pkg::OFF_LEG_CMD[ch]);
				hit_data[ch] = (off == dsr_pkg::OFF_LEG_DATA[ch]);
				hit_ext[ch] = (off == dsr_pkg::OFF_LEG_EXT[ch]);
			end else begin
				hit_cmd[ch] = 1'b0;
				hit_data[ch] = 1'b0;
				hit_ext[ch] = 1'b0;
			end
		end
		for (int s = 0; s < 10; s++) begin
			hit_sh[s] = in_window && (off == dsr_pkg::OFF_SHARED[s]);
		end
		for (int d = 0; d < 4; d++) begin
			hit_dctl[d] = (region == 4'(dsr_pkg::RGN_DMA_BASE + d)) &&
				(off == dsr_pkg::DMA_OFF_CTRL);
			hit_dcnt[d] = (region == 4'(dsr_pkg::RGN_DMA_BASE + d)) &&
				(off == dsr_pkg::DMA_OFF_COUNT);
			hit_dlvl[d] = (region == 4'(dsr_pkg::RGN_DMA_BASE + d)) &&
				(off == dsr_pkg::DMA_OFF_LEVEL);
		end
	end

	// Per-channel data path with transmit and receive buffers.
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			assign wr_data[ch] = bus_req_i.wr && hit_data[ch];
			assign rd_data[ch] = bus_req_i.rd && hit_data[ch];

			// Software writes take the buffer ahead of the DMA engine.
			assign fin_valid[2*ch] = wr_data[ch] || (dma_tx_valid_i[ch] && st_q.dma_en[2*ch]);
			assign fin_data[2*ch] = wr_data[ch] ? bus_req_i.wdata : dma_tx_data_i[ch];
			assign dma_tx_ready_o[ch] = fin_ready[2*ch] && st_q.dma_en[2*ch] && !wr_data[ch];
			assign fout_ready[2*ch] = ser_tx_ready_i[ch];
			assign ser_tx_valid_o[ch] = fout_valid[2*ch];
			assign ser_tx_data_o[ch] = fout_data[2*ch];

			// Software reads take the buffer ahead of the DMA engine.
			assign fin_valid[2*ch+1] = ser_rx_valid_i[ch];
			assign fin_data[2*ch+1] = ser_rx_data_i[ch];
			assign ser_rx_ready_o[ch] = fin_ready[2*ch+1];
			assign dma_rx_valid_o[ch] = fout_valid[2*ch+1] && st_q.dma_en[2*ch+1] &&
				!rd_data[ch];
			assign dma_rx_data_o[ch] = fout_data[2*ch+1];
			assign fout_ready[2*ch+1] = rd_data[ch] ||
				(dma_rx_ready_i[ch] && st_q.dma_en[2*ch+1]);

			assign dma_xfer[2*ch] = dma_tx_valid_i[ch] && dma_tx_ready_o[ch];
			assign dma_xfer[2*ch+1] = dma_rx_valid_o[ch] && dma_rx_ready_i[ch];

			// Status seen through the command register.
			always_comb begin
				status[ch] = '0;
				status[ch][dsr_pkg::ST_RX_AVAIL] = fout_valid[2*ch+1];
				status[ch][dsr_pkg::ST_TX_ROOM] = fin_ready[2*ch];
				status[ch][dsr_pkg::ST_EXT_CLK] = st_q.ext_lvl[ch];
				status[ch][dsr_pkg::ST_TX_EMPTY] = !fout_valid[2*ch];
			end

			for (genvar dir = 0; dir < 2; dir++) begin : g_dir
				dsr_fifo #(
					.WIDTH(dsr_pkg::DATA_W),
					.DEPTH(dsr_pkg::FIFO_DEPTH)
				) u_fifo (
					.clk_i(clk_i),
					.sys_rst_i(sys_rst_i),
					.in_valid_i(fin_valid[2*ch+dir]),
					.in_ready_o(fin_ready[2*ch+dir]),
					.in_data_i(fin_data[2*ch+dir]),
					.out_valid_o(fout_valid[2*ch+dir]),
					.out_ready_i(fout_ready[2*ch+dir]),
					.out_data_o(fout_data[2*ch+dir]),
					.level_o(flevel[2*ch+dir])
				);
			end
		end
	endgenerate

	// Next-state logic for every register of the block.
	always_comb begin
		st_d = st_q;
		st_d.rdata = '0;
		for (int ch = 0; ch < 2; ch++) begin
			// External clock pin: three stages, a change counts once the last two agree.
			st_d.sync[ch] = {st_q.sync[ch][1:0], external_serial_clock_pin_i[ch]};
			if (st_q.sync[ch][1] == st_q.sync[ch][2]) begin
				st_d.ext_lvl[ch] = st_q.sync[ch][2];
			end
			// Command register: first write picks the pointer, the second writes the value.
			if (bus_req_i.wr && hit_cmd[ch]) begin
				case (st_q.phase[ch])
					dsr_pkg::PH_INDEX: begin
						st_d.ptr[ch] = bus_req_i.wdata[1:0];
						st_d.phase[ch] = dsr_pkg::PH_VALUE;
					end
					dsr_pkg::PH_VALUE: begin
						if (st_q.ptr[ch] == dsr_pkg::IND_CTRL) begin
							st_d.cfg[ch].ctrl = bus_req_i.wdata;
						end else if (st_q.ptr[ch] == dsr_pkg::IND_MODE) begin
							st_d.cfg[ch].mode = bus_req_i.wdata;
						end
						st_d.phase[ch] = dsr_pkg::PH_INDEX;
					end
					default: begin
						st_d.phase[ch] = dsr_pkg::PH_INDEX;
					end
				endcase
			end
			// A read returns the pointed register and rearms the pointer.
			if (bus_req_i.rd && hit_cmd[ch]) begin
				if (st_q.ptr[ch] == dsr_pkg::IND_CTRL) begin
					st_d.rdata = st_q.cfg[ch].ctrl;
				end else if (st_q.ptr[ch] == dsr_pkg::IND_MODE) begin
					st_d.rdata = st_q.cfg[ch].mode;
				end else if (st_q.ptr[ch] == dsr_pkg::IND_STATUS) begin
					st_d.rdata = status[ch];
				end
				st_d.ptr[ch] = dsr_pkg::IND_CTRL;
				st_d.phase[ch] = dsr_pkg::PH_INDEX;
			end
			if (bus_req_i.wr && hit_ext[ch]) begin
				st_d.cfg[ch].ext = bus_req_i.wdata;
			end
			if (bus_req_i.rd && hit_ext[ch]) begin
				st_d.rdata = st_q.cfg[ch].ext;
			end
			// Data register read pops the receive buffer; empty reads zero.
			if (rd_data[ch] && fout_valid[2*ch+1]) begin
				st_d.rdata = fout_data[2*ch+1];
			end
		end
		// Shared group; a write at the start offset loads both start slots.
		for (int s = 0; s < 10; s++) begin
			if (bus_req_i.wr && hit_sh[s]) begin
				st_d.shared[s] = bus_req_i.wdata;
			end
		end
		for (int s = 9; s >= 0; s--) begin
			if (bus_req_i.rd && hit_sh[s]) begin
				st_d.rdata = st_q.shared[s];
			end
		end
		// DMA regions: enable, transfer count and buffer level.
		for (int d = 0; d < 4; d++) begin
			if (bus_req_i.wr && hit_dctl[d]) begin
				st_d.dma_en[d] = bus_req_i.wdata[dsr_pkg::DMA_CTRL_EN_BIT];
			end
			if (bus_req_i.rd && hit_dctl[d]) begin
				st_d.rdata = {7'h00, st_q.dma_en[d]};
			end
			// A transfer in the clearing cycle is still counted.
			if (bus_req_i.wr && hit_dcnt[d]) begin
				st_d.dma_cnt[d] = dma_xfer[d] ? 8'h01 : 8'h00;
			end else if (dma_xfer[d]) begin
				st_d.dma_cnt[d] = 8'(st_q.dma_cnt[d] + 1'b1);
			end
			if (bus_req_i.rd && hit_dcnt[d]) begin
				st_d.rdata = st_q.dma_cnt[d];
			end
			if (bus_req_i.rd && hit_dlvl[d]) begin
				st_d.rdata = 8'(flevel[d]);
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Registered outputs.
	assign reg_rdata_o = st_q.rdata;
	assign chan_cfg_o = st_q.cfg;
	assign shared_regs_o = st_q.shared;
	assign clk_src_ext_o[0] = st_q.cfg[0].mode[dsr_pkg::MODE_CLK_EXT_BIT];
	assign clk_src_ext_o[1] = st_q.cfg[1].mode[dsr_pkg::MODE_CLK_EXT_BIT];
endmodule // dsr_decoder
`default_nettype wire

//--- verification/dsr_serial_model.sv
// Serial engine stand-in: takes transmit bytes and offers receive bytes.
`timescale 1ns/100ps
`default_nettype none
module dsr_serial_model (
	// Clock and stall control.
	input wire logic clk_i,
	input wire logic stall_i,
	// Transmit side.
	input wire logic [1:0] tx_valid_i,
	output logic [1:0] tx_ready_o,
	input wire logic [1:0][7:0] tx_data_i,
	// Receive side.
	output logic [1:0] rx_valid_o,
	input wire logic [1:0] rx_ready_i,
	output logic [1:0][7:0] rx_data_o
);
	logic [7:0] got[2][$];
	logic [1:0] hs_q;
	logic [1:0][7:0] d_q;
	initial begin
		rx_valid_o = 2'b00;
		rx_data_o = 16'h0000;
	end
	assign tx_ready_o = {2{!stall_i}};
	always @(negedge clk_i) begin
		hs_q = tx_valid_i & tx_ready_o;
		d_q = tx_data_i;
	end
	always @(posedge clk_i) begin
		for (int c = 0; c < 2; c++) begin
			if (hs_q[c]) got[c].push_back(d_q[c]);
		end
	end
	task automatic send(input int c, input logic [7:0] b);
		logic r;
		@(posedge clk_i);
		rx_valid_o[c] <= 1'b1;
		rx_data_o[c] <= b;
		do begin
			@(negedge clk_i);
			r = rx_ready_i[c];
			@(posedge clk_i);
		end while (!r);
		rx_valid_o[c] <= 1'b0;
		rx_data_o[c] <= ~b;
	endtask
endmodule // dsr_serial_model
`default_nettype wire

//--- verification/dsr_decoder_assertions.sv
// Port checks for the register decoder.
`timescale 1ns/100ps
`default_nettype none
module dsr_decoder_assertions (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port.
	input wire dsr_pkg::dsr_bus_req_t bus_req_i,
	input wire logic [7:0] reg_rdata_o,
	// Streams.
	input wire logic [1:0] ser_tx_valid_o,
	input wire logic [1:0] ser_tx_ready_i,
	input wire logic [1:0][7:0] ser_tx_data_o,
	input wire logic [1:0] dma_tx_ready_o,
	input wire logic [1:0] dma_rx_valid_o,
	// Configuration.
	input wire dsr_pkg::dsr_chan_cfg_t [1:0] chan_cfg_o,
	input wire logic [9:0][7:0] shared_regs_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	rdata_idle_a: assert property (
		!bus_req_i.rd |=> reg_rdata_o == 8'h00) else $error("read data outside answer");
	unmapped_read_a: assert property (
		bus_req_i.rd && bus_req_i.addr[11:9] == 3'h0 && bus_req_i.addr[7:0] == 8'hF0
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	shared_same_a: assert property (
		bus_req_i.wr && bus_req_i.addr[11:9] == 3'h0 && bus_req_i.addr[7:0] == 8'h60
		|=> shared_regs_o[0] == $past(bus_req_i.wdata)) else $error("recovery write lost");
	start_both_a: assert property (
		bus_req_i.wr && bus_req_i.addr[11:9] == 3'h0 && bus_req_i.addr[7:0] == 8'h70
		|=> shared_regs_o[1] == $past(bus_req_i.wdata) && shared_regs_o[2] == shared_regs_o[1])
		else $error("start write not shared");
	cfg_hold_a: assert property (
		!bus_req_i.wr |=> $stable(chan_cfg_o) && $stable(shared_regs_o))
		else $error("config changed without write");
	dma_region_a: assert property (
		bus_req_i.wr && bus_req_i.addr[11:8] == 4'h2 |=> $stable(chan_cfg_o))
		else $error("dma write reached channel config");
	tx_hold_a: assert property (
		ser_tx_valid_o[0] && !ser_tx_ready_i[0] |=> ser_tx_valid_o[0] && $stable(ser_tx_data_o[0]))
		else $error("tx head dropped while stalled");
	sw_tx_first_a: assert property (
		bus_req_i.wr && bus_req_i.addr == 12'h030 |-> !dma_tx_ready_o[0])
		else $error("dma tx not held off");
	sw_rx_first_a: assert property (
		bus_req_i.rd && bus_req_i.addr == 12'h030 |-> !dma_rx_valid_o[0])
		else $error("dma rx not held off");
endmodule // dsr_decoder_assertions
bind dsr_decoder dsr_decoder_assertions dsr_decoder_assertions_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .bus_req_i(bus_req_i), .reg_rdata_o(reg_rdata_o),
	.ser_tx_valid_o(ser_tx_valid_o), .ser_tx_ready_i(ser_tx_ready_i),
	.ser_tx_data_o(ser_tx_data_o), .dma_tx_ready_o(dma_tx_ready_o),
	.dma_rx_valid_o(dma_rx_valid_o), .chan_cfg_o(chan_cfg_o), .shared_regs_o(shared_regs_o));
`default_nettype wire

//--- verification/dsr_decoder_tb.sv
// Self-checking bench for the dual serial register decoder.
`timescale 1ns/100ps
`default_nettype none
module dsr_decoder_tb;
	typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e;} dsr_row_t;
	logic clk_i, sys_rst_i, stall, r;
	dsr_pkg::dsr_bus_req_t req;
	logic [7:0] rdata;
	logic [1:0] tx_v, tx_r, rx_v, rx_r, dtx_v, dtx_r, drx_v, drx_r, pin, ext;
	logic [1:0][7:0] tx_d, rx_d, dtx_d, drx_d;
	dsr_pkg::dsr_chan_cfg_t [1:0] cfg;
	logic [9:0][7:0] shr;
	int mismatches, cmp_count, cyc;
	dsr_row_t rows [9] = '{'{12'h060, 8'h11, 8'h11}, '{12'h170, 8'h22, 8'h22},
		'{12'h0E0, 8'h33, 8'h33}, '{12'h1A0, 8'h44, 8'h44}, '{12'h050, 8'h55, 8'h55},
		'{12'h108, 8'h66, 8'h66}, '{12'h0F0, 8'h77, 8'h00}, '{12'h10C, 8'h88, 8'h00},
		'{12'h600, 8'h99, 8'h00}};
	dsr_decoder dsr_decoder_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(req),
		.reg_rdata_o(rdata), .ser_tx_valid_o(tx_v), .ser_tx_ready_i(tx_r), .ser_tx_data_o(tx_d),
		.ser_rx_valid_i(rx_v), .ser_rx_ready_o(rx_r), .ser_rx_data_i(rx_d),
		.dma_tx_valid_i(dtx_v), .dma_tx_ready_o(dtx_r), .dma_tx_data_i(dtx_d),
		.dma_rx_valid_o(drx_v), .dma_rx_ready_i(drx_r), .dma_rx_data_o(drx_d),
		.external_serial_clock_pin_i(pin), .clk_src_ext_o(ext), .chan_cfg_o(cfg),
		.shared_regs_o(shr));
	dsr_serial_model dsr_serial_model_inst (.clk_i(clk_i), .stall_i(stall), .tx_valid_i(tx_v),
		.tx_ready_o(tx_r), .tx_data_i(tx_d), .rx_valid_o(rx_v), .rx_ready_i(rx_r), .rx_data_o(rx_d));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %0t got %h want %h", $time, g, e);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] w);
		@(posedge clk_i);
		req.addr <= a;
		req.wdata <= w;
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_i);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		req = '0;
		stall = 1'b0;
		pin = 2'b00;
		dtx_v = 2'b00;
		dtx_d = 16'h0000;
		drx_r = 2'b00;
		mismatches = 0;
		cmp_count = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1 chk({6'h00, rx_r}, 8'h03);
		chk({6'h00, tx_v}, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		rd(12'h10A, 8'h55);
		chk(shr[1], 8'h22);
		chk(shr[2], 8'h22);
		rd(12'h020, 8'h00);
		wr(12'h020, 8'h00);
		wr(12'h020, 8'h5A);
		#1 chk(cfg[0].ctrl, 8'h5A);
		rd(12'h020, 8'h5A);
		wr(12'h100, 8'h01);
		wr(12'h100, 8'h01);
		@(posedge clk_i);
		#1 chk({6'h00, ext}, 8'h02);
		wr(12'h100, 8'h02);
		rd(12'h100, 8'h0A);
		@(posedge clk_i);
		pin <= 2'b10;
		repeat (6) @(posedge clk_i);
		wr(12'h100, 8'h02);
		rd(12'h100, 8'h0E);
		stall <= 1'b1;
		for (int k = 1; k < 6; k++) wr(12'h030, 8'(k));
		rd(12'h220, 8'h04);
		wr(12'h020, 8'h02);
		rd(12'h020, 8'h00);
		@(posedge clk_i);
		stall <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(8'(dsr_serial_model_inst.got[0].size()), 8'h04);
		chk(dsr_serial_model_inst.got[0][3], 8'h04);
		dsr_serial_model_inst.send(1, 8'h3C);
		rd(12'h010, 8'h3C);
		rd(12'h010, 8'h00);
		dsr_serial_model_inst.send(0, 8'hA5);
		rd(12'h106, 8'hA5);
		wr(12'h200, 8'h01);
		rd(12'h200, 8'h01);
		@(posedge clk_i);
		dtx_v <= 2'b01;
		dtx_d <= 16'h00C3;
		do begin
			@(negedge clk_i);
			r = dtx_r[0];
			@(posedge clk_i);
		end while (!r);
		dtx_v <= 2'b00;
		dtx_d <= 16'hFF3C;
		repeat (8) @(posedge clk_i);
		chk(dsr_serial_model_inst.got[0][4], 8'hC3);
		rd(12'h210, 8'h01);
		chk(shr[0], 8'h11);
		chk(cfg[0].ext, 8'h55);
		wr(12'h100, 8'h01);
		rd(12'h100, 8'h01);
		wr(12'h300, 8'h01);
		dsr_serial_model_inst.send(0, 8'h5A);
		#1 chk({6'h00, drx_v}, 8'h01);
		chk(drx_d[0], 8'h5A);
		rd(12'h030, 8'h5A);
		#1 chk({6'h00, drx_v}, 8'h00);
		dsr_serial_model_inst.send(0, 8'h6B);
		#1 chk(drx_d[0], 8'h6B);
		@(posedge clk_i);
		drx_r <= 2'b01;
		@(posedge clk_i);
		drx_r <= 2'b00;
		rd(12'h310, 8'h01);
		rd(12'h320, 8'h00);
		wrap_up();
	end
endmodule // dsr_decoder_tb
`default_nettype wire
